// ---- rtl/adc_chan_pkg.sv ----
// Package: register map, field layout, reset values and carriers for the
// per-channel converter control and status block.
// Assumes a 16-bit register port with one word per index.
`default_nettype none

package adc_chan_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CHAN = 22;
  localparam int HIGH_CHAN = 6;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int CHAN_IDX_W = 5;
  localparam int CFG_PER_WORD = 8;

  // ****************************************
  // Register offsets (word index)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_EARLY_LOW = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_EARLY_HIGH = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CFG0_LOW = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CFG0_HIGH = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CFG1_LOW = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN_LOW = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN_HIGH = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_READY_LOW = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_READY_HIGH = 4'h8;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int FMT_BIT = 0;
  localparam int TYPE_BIT = 1;
  localparam int CFG1_USED_W = 12;
  localparam logic [NUM_CHAN-1:0] CHAN_RESET = 22'h000000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [NUM_CHAN-1:0] early_set;
    logic [NUM_CHAN-1:0] ready_set;
    logic buf_rd;
    logic [CHAN_IDX_W-1:0] buf_chan;
  } engine_evt_s;

  typedef struct packed {
    logic [NUM_CHAN-1:0] balanced_input_select;
    logic [NUM_CHAN-1:0] signed_result_select;
    logic [NUM_CHAN-1:0] channel_irq_enable;
  } chan_cfg_s;

endpackage

`default_nettype wire

// ---- rtl/chan_flag.sv ----
// Module: one hardware-set flag per channel, cleared by a result buffer read.
// Assumes set and clear arrive as one-cycle pulses on the core clock.
`default_nettype none

module chan_flag (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);

  logic next_flag;

  // Set wins over clear so an event in the read cycle is kept
  always_comb begin
    next_flag = flag_o;
    if (clr_i) begin
      next_flag = 1'b0;
    end
    if (set_i) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/adc_chan_ctrl.sv ----
// Module: channel configuration, interrupt enables, early interrupt status and
// result-ready status of a 22-input converter, behind a 16-bit register port.
// Assumes the conversion engine drives one-cycle event pulses on the same clock.
`default_nettype none

// Function
// [RULE1] Early flags 16..21 in high status bits 5:0
// [RULE2] Early flag holds until buffer read clears it
// [RULE3] Unused high-word bits read zero, ignore writes
// [RULE4] Type bit: one differential, zero single-ended
// [RULE5] Format bit: one signed, zero unsigned
// [RULE6] Odd bit type, even bit format, ascending
// [RULE7] Third config word bits 11:0, upper zero
// [RULE8] Per-channel enable gates shared and own interrupt
// [RULE9] Read-only ready flag set by conversion
// [RULE10] Ready flags ignore software writes
// [RULE11] All implemented bits zero after reset
// [RULE12] Early flags 0..15 in low status word
// [RULE13] Buffer read clears channel ready flag
module adc_chan_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [adc_chan_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [adc_chan_pkg::WORD_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [adc_chan_pkg::WORD_W-1:0] reg_rdata_o,
  input wire logic [adc_chan_pkg::NUM_CHAN-1:0] early_event_i,
  input wire logic [adc_chan_pkg::NUM_CHAN-1:0] conv_done_i,
  input wire logic buf_rd_i,
  input wire logic [adc_chan_pkg::CHAN_IDX_W-1:0] buf_chan_i,
  output logic [adc_chan_pkg::NUM_CHAN-1:0] balanced_input_select_o,
  output logic [adc_chan_pkg::NUM_CHAN-1:0] signed_result_select_o,
  output logic [adc_chan_pkg::NUM_CHAN-1:0] chan_irq_o,
  output logic common_irq_o
);

  // ****************************************
  // Request and event carriers
  // ****************************************
  adc_chan_pkg::reg_req_s req;
  adc_chan_pkg::engine_evt_s evt;
  adc_chan_pkg::chan_cfg_s cfg;
  adc_chan_pkg::chan_cfg_s next_cfg;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign evt = '{early_set: early_event_i, ready_set: conv_done_i, buf_rd: buf_rd_i, buf_chan: buf_chan_i};

  // ****************************************
  // Configuration registers
  // ****************************************
  always_comb begin
    next_cfg = cfg;
    if (req.wr) begin
      case (req.addr)
        adc_chan_pkg::OFS_CFG0_LOW: begin
          for (int i = 0; i < adc_chan_pkg::CFG_PER_WORD; i++) begin
            next_cfg.balanced_input_select[i] = req.wdata[2*i+adc_chan_pkg::TYPE_BIT]; // RULE6
            next_cfg.signed_result_select[i] = req.wdata[2*i+adc_chan_pkg::FMT_BIT]; // RULE6
          end
        end
        adc_chan_pkg::OFS_CFG0_HIGH: begin
          for (int i = 0; i < adc_chan_pkg::CFG_PER_WORD; i++) begin
            next_cfg.balanced_input_select[i+8] = req.wdata[2*i+adc_chan_pkg::TYPE_BIT];
            next_cfg.signed_result_select[i+8] = req.wdata[2*i+adc_chan_pkg::FMT_BIT];
          end
        end
        adc_chan_pkg::OFS_CFG1_LOW: begin
          for (int i = 0; i < adc_chan_pkg::HIGH_CHAN; i++) begin
            next_cfg.balanced_input_select[i+16] = req.wdata[2*i+adc_chan_pkg::TYPE_BIT]; // RULE7
            next_cfg.signed_result_select[i+16] = req.wdata[2*i+adc_chan_pkg::FMT_BIT]; // RULE7
          end
        end
        adc_chan_pkg::OFS_IRQ_EN_LOW: begin
          next_cfg.channel_irq_enable[15:0] = req.wdata;
        end
        adc_chan_pkg::OFS_IRQ_EN_HIGH: begin
          next_cfg.channel_irq_enable[21:16] = req.wdata[adc_chan_pkg::HIGH_CHAN-1:0]; // RULE3
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg <= '{default: adc_chan_pkg::CHAN_RESET}; // RULE11
    end else begin
      cfg <= next_cfg;
    end
  end

  // ****************************************
  // Hardware-set flags
  // ****************************************
  // Early and ready flags are write-protected: software only sees them
  logic [adc_chan_pkg::NUM_CHAN-1:0] buf_clr;
  logic [adc_chan_pkg::NUM_CHAN-1:0] early_flag;
  logic [adc_chan_pkg::NUM_CHAN-1:0] ready_flag;

  always_comb begin
    buf_clr = adc_chan_pkg::CHAN_RESET;
    if (evt.buf_rd && (evt.buf_chan < 5'(adc_chan_pkg::NUM_CHAN))) begin
      buf_clr[evt.buf_chan] = 1'b1; // RULE2 RULE13
    end
  end

  for (genvar c = 0; c < adc_chan_pkg::NUM_CHAN; c++) begin : g_flag
    chan_flag early_q (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .set_i(evt.early_set[c]), // RULE1 RULE12
      .clr_i(buf_clr[c]), // RULE2
      .flag_o(early_flag[c])
    );
    chan_flag ready_q (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .set_i(evt.ready_set[c]), // RULE9
      .clr_i(buf_clr[c]), // RULE10 RULE13
      .flag_o(ready_flag[c])
    );
  end

  // ****************************************
  // Interrupt outputs
  // ****************************************
  // Registered so each output comes from a flop; one cycle after the flag
  logic [adc_chan_pkg::NUM_CHAN-1:0] next_chan_irq;
  logic next_common_irq;

  always_comb begin
    next_chan_irq = ready_flag & cfg.channel_irq_enable; // RULE8
    next_common_irq = |next_chan_irq; // RULE8
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      chan_irq_o <= adc_chan_pkg::CHAN_RESET;
      common_irq_o <= 1'b0;
      balanced_input_select_o <= adc_chan_pkg::CHAN_RESET;
      signed_result_select_o <= adc_chan_pkg::CHAN_RESET;
    end else begin
      chan_irq_o <= next_chan_irq;
      common_irq_o <= next_common_irq;
      balanced_input_select_o <= next_cfg.balanced_input_select; // RULE4
      signed_result_select_o <= next_cfg.signed_result_select; // RULE5
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [adc_chan_pkg::WORD_W-1:0] next_rdata;

  always_comb begin
    next_rdata = adc_chan_pkg::WORD_ZERO;
    if (req.rd) begin
      case (req.addr)
        adc_chan_pkg::OFS_EARLY_LOW: begin
          next_rdata = early_flag[15:0]; // RULE12
        end
        adc_chan_pkg::OFS_EARLY_HIGH: begin
          next_rdata[adc_chan_pkg::HIGH_CHAN-1:0] = early_flag[21:16]; // RULE1 RULE3
        end
        adc_chan_pkg::OFS_CFG0_LOW: begin
          for (int i = 0; i < adc_chan_pkg::CFG_PER_WORD; i++) begin
            next_rdata[2*i+adc_chan_pkg::TYPE_BIT] = cfg.balanced_input_select[i];
            next_rdata[2*i+adc_chan_pkg::FMT_BIT] = cfg.signed_result_select[i];
          end
        end
        adc_chan_pkg::OFS_CFG0_HIGH: begin
          for (int i = 0; i < adc_chan_pkg::CFG_PER_WORD; i++) begin
            next_rdata[2*i+adc_chan_pkg::TYPE_BIT] = cfg.balanced_input_select[i+8];
            next_rdata[2*i+adc_chan_pkg::FMT_BIT] = cfg.signed_result_select[i+8];
          end
        end
        adc_chan_pkg::OFS_CFG1_LOW: begin
          for (int i = 0; i < adc_chan_pkg::HIGH_CHAN; i++) begin
            next_rdata[2*i+adc_chan_pkg::TYPE_BIT] = cfg.balanced_input_select[i+16]; // RULE7
            next_rdata[2*i+adc_chan_pkg::FMT_BIT] = cfg.signed_result_select[i+16]; // RULE7
          end
        end
        adc_chan_pkg::OFS_IRQ_EN_LOW: begin
          next_rdata = cfg.channel_irq_enable[15:0];
        end
        adc_chan_pkg::OFS_IRQ_EN_HIGH: begin
          next_rdata[adc_chan_pkg::HIGH_CHAN-1:0] = cfg.channel_irq_enable[21:16]; // RULE3
        end
        adc_chan_pkg::OFS_READY_LOW: begin
          next_rdata = ready_flag[15:0]; // RULE9
        end
        adc_chan_pkg::OFS_READY_HIGH: begin
          next_rdata[adc_chan_pkg::HIGH_CHAN-1:0] = ready_flag[21:16]; // RULE3 RULE9
        end
        default: begin
          next_rdata = adc_chan_pkg::WORD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= adc_chan_pkg::WORD_ZERO;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/adc_chan_ctrl_chk.sv ----
// Checker: register port and flag timing of the channel control block.
// Assumes it is bound to adc_chan_ctrl and sees only its ports.
`default_nettype none

module adc_chan_ctrl_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [21:0] early_event_i,
  input wire logic [21:0] conv_done_i,
  input wire logic buf_rd_i,
  input wire logic [4:0] buf_chan_i,
  input wire logic [21:0] balanced_input_select_o,
  input wire logic [21:0] signed_result_select_o,
  input wire logic [21:0] chan_irq_o,
  input wire logic common_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // Sequences and assertions
  // ****************************************
  sequence rd_at(logic [3:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence buf16_then_rd;
    buf_rd_i && buf_chan_i == 5'h10 && !early_event_i[16] ##1 !early_event_i[16] ##[0:1] rd_at(4'h1);
  endsequence
  a_high_zero: assert property (reg_rd_i && reg_addr_i inside {4'h1, 4'h6, 4'h8} |=> reg_rdata_o[15:6] == 10'h000)
    else $error("upper status bits not zero");
  a_cfg1_top: assert property (rd_at(4'h4) |=> reg_rdata_o[15:12] == 4'h0)
    else $error("third config word top bits not zero");
  a_cfg_pair: assert property (reg_wr_i && reg_addr_i == 4'h2 |=> balanced_input_select_o[7] == $past(reg_wdata_i[15])
    && signed_result_select_o[7] == $past(reg_wdata_i[14]))
    else $error("config pair of channel 7 wrong");
  a_cfg_third: assert property (reg_wr_i && reg_addr_i == 4'h4 |=> balanced_input_select_o[21] == $past(reg_wdata_i[11])
    && signed_result_select_o[16] == $past(reg_wdata_i[0]))
    else $error("third config word mapping wrong");
  a_common_or: assert property (common_irq_o == |chan_irq_o)
    else $error("shared interrupt differs from channel terms");
  a_ready_seen: assert property (conv_done_i[0] ##1 !buf_rd_i ##[0:1] rd_at(4'h7) |=> reg_rdata_o[0])
    else $error("ready flag not visible after conversion");
  a_early_high: assert property (early_event_i[16] ##1 !buf_rd_i ##[0:1] rd_at(4'h1) |=> reg_rdata_o[0])
    else $error("early flag 16 not set");
  a_early_clear: assert property (buf16_then_rd |=> !reg_rdata_o[0])
    else $error("early flag 16 survived buffer read");
  a_irq_clear: assert property (buf_rd_i && buf_chan_i == 5'h00 && !conv_done_i[0] |-> ##2 !chan_irq_o[0])
    else $error("channel 0 interrupt kept after buffer read");
endmodule

bind adc_chan_ctrl adc_chan_ctrl_chk i_chk (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .early_event_i, .conv_done_i, .buf_rd_i, .buf_chan_i, .balanced_input_select_o,
  .signed_result_select_o, .chan_irq_o, .common_irq_o);

`default_nettype wire

// ---- testbench/adc_chan_ctrl_test.sv ----
// Testbench: register and event sequences for the channel control block.
// Assumes the checker is bound in; every input is driven from here.
`default_nettype none

module adc_chan_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, brd = 1'b0, cmn;
  logic [3:0] addr = 4'h0;
  logic [4:0] bch = 5'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [21:0] early = 22'h000000, done = 22'h000000, cirq, bal, sgn, exp_bal, exp_sgn;
  logic [47:0] cfgw = {16'h0FFF, 16'h5A3C, 16'hA5C3};
  int errors = 0, checks = 0, cycles = 0;
  adc_chan_ctrl i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .early_event_i(early), .conv_done_i(done), .buf_rd_i(brd), .buf_chan_i(bch),
    .balanced_input_select_o(bal), .signed_result_select_o(sgn), .chan_irq_o(cirq), .common_irq_o(cmn));
  initial begin
    forever #2 clk = ~clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Ceiling well above the hundred-odd cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks = checks + 1;
    if (seen !== expv) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, e);
  endtask
  task automatic pulse(input logic [21:0] e, input logic [21:0] d);
    @(posedge clk);
    early <= e;
    done <= d;
    @(posedge clk);
    early <= 22'h000000;
    done <= 22'h000000;
  endtask
  task automatic buf_read(input logic [4:0] c);
    @(posedge clk);
    brd <= 1'b1;
    bch <= c;
    @(posedge clk);
    brd <= 1'b0;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    do_reset();
    for (int a = 0; a < 16; a++) begin
      rd_reg(a[3:0], 16'h0000);
    end
    wr_reg(4'h2, 16'hA5C3);
    wr_reg(4'h3, 16'h5A3C);
    wr_reg(4'h4, 16'hFFFF);
    rd_reg(4'h2, 16'hA5C3);
    rd_reg(4'h4, 16'h0FFF);
    for (int c = 0; c < 22; c++) begin
      exp_bal[c] = cfgw[2*c+1];
      exp_sgn[c] = cfgw[2*c];
    end
    check(bal, exp_bal);
    check(sgn, exp_sgn);
    wr_reg(4'h5, 16'hFFFF);
    wr_reg(4'h6, 16'hFFFF);
    wr_reg(4'h1, 16'hFFFF);
    wr_reg(4'h7, 16'hFFFF);
    rd_reg(4'h6, 16'h003F);
    rd_reg(4'h1, 16'h0000);
    rd_reg(4'h7, 16'h0000);
    pulse(22'h000002, 22'h200001);
    rd_reg(4'h7, 16'h0001);
    rd_reg(4'h8, 16'h0020);
    rd_reg(4'h0, 16'h0002);
    pulse(22'h010000, 22'h000000);
    rd_reg(4'h1, 16'h0001);
    check(cirq, 22'h200001);
    check(cmn, 1'b1);
    buf_read(5'h00);
    rd_reg(4'h7, 16'h0000);
    check(cirq, 22'h200000);
    rd_reg(4'h1, 16'h0001);
    buf_read(5'h10);
    rd_reg(4'h1, 16'h0000);
    buf_read(5'h01);
    rd_reg(4'h0, 16'h0000);
    buf_read(5'h16);
    rd_reg(4'h8, 16'h0020);
    // Conversion and buffer read of one channel in the same cycle: the set is kept
    @(posedge clk);
    done <= 22'h000004;
    brd <= 1'b1;
    bch <= 5'h02;
    @(posedge clk);
    done <= 22'h000000;
    brd <= 1'b0;
    rd_reg(4'h7, 16'h0004);
    buf_read(5'h02);
    rd_reg(4'h7, 16'h0000);
    wr_reg(4'h6, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    check(cirq, 22'h000000);
    check(cmn, 1'b0);
    @(posedge clk);
    do_reset();
    rd_reg(4'h2, 16'h0000);
    check(bal, 22'h000000);
    test_done();
  end
endmodule

`default_nettype wire
